// *** hw/arch_reset_pkg.sv ***
// constants, field layouts and types for the architectural reset sequencer
`default_nettype none
package arch_reset_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_ENTRIES = 8;
  localparam int NUM_SEGS = 10;
  localparam int NUM_PERF = 2;
  localparam int FPU_W = 80;
  localparam int MM_W = 64;
  localparam int VEC_W = 128;
  localparam int SYNC_PINS = 3;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CR0       = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FLAGS     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ACCUM     = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_DATA_D    = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_FPU_CW    = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_FPU_SW    = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_FPU_TAG   = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_FPU_SELS  = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_FPU_DPTR  = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_FPU_IPTR  = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_VEC_CSR   = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_TSC_LO    = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_TSC_HI    = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_PERF_SEL  = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_PERF_CNT  = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_MEMORY_TYPE_RANGES_EN   = 8'h48;
  localparam logic [ADDR_W-1:0] OFF_LAPIC     = 8'h4c;
  localparam logic [ADDR_W-1:0] OFF_MSR_MISC  = 8'h50;
  localparam logic [ADDR_W-1:0] OFF_MCHK      = 8'h54;
  localparam logic [ADDR_W-1:0] OFF_FILE_SEL  = 8'h58;
  localparam logic [ADDR_W-1:0] OFF_FILE_DATA = 8'h5c;
  localparam logic [ADDR_W-1:0] OFF_FPU_INIT  = 8'h60;
  localparam logic [ADDR_W-1:0] PERF_STRIDE   = 8'h04;
  // reset values
  localparam logic [31:0] CR0_POWERUP   = 32'h6000_0010;
  localparam logic [31:0] CR0_KEEP_MASK = 32'h6000_0000;
  localparam logic [31:0] CR0_SET_BITS  = 32'h0000_0010;
  localparam logic [31:0] FLAGS_RESET   = 32'h0000_0002;
  localparam logic [31:0] FLAGS_UNDEF   = 32'hffc0_0000;
  localparam logic [15:0] CS_SELECTOR   = 16'hf000;
  localparam logic [31:0] CS_BASE       = 32'hffff_0000;
  localparam logic [15:0] ZERO_SELECTOR = 16'h0000;
  localparam logic [31:0] ZERO_BASE     = 32'h0000_0000;
  localparam logic [31:0] SEG_LIMIT     = 32'h0000_ffff;
  localparam logic [7:0]  AR_PRW_ACC    = 8'h83;
  localparam logic [7:0]  AR_PRW        = 8'h82;
  localparam logic [15:0] FCW_RESET     = 16'h0040;
  localparam logic [15:0] FCW_FINIT     = 16'h037f;
  localparam logic [15:0] FSW_CLEAR     = 16'h0000;
  localparam logic [15:0] FTW_RESET     = 16'h5555;
  localparam logic [15:0] FTW_FINIT     = 16'hffff;
  localparam logic [31:0] VCSR_RESET    = 32'h0000_1f80;
  localparam logic [31:0] BUILTIN_SELF_TEST_FAIL     = 32'h0000_0001;
  // segment indices
  localparam int SEG_CS = 0;
  localparam int SEG_LOCAL_DESCRIPTOR_TABLE_REG = 6;
  localparam int SEG_GLOBAL_DESCRIPTOR_TABLE_REG = 8;
  // register-file window select fields
  localparam int SEL_WORD_LSB = 0;
  localparam int SEL_ENTRY_LSB = 2;
  localparam int SEL_FILE_LSB = 8;
  localparam logic [1:0] FILE_SEG = 2'h0;
  localparam logic [1:0] FILE_FPU = 2'h1;
  localparam logic [1:0] FILE_MM  = 2'h2;
  localparam logic [1:0] FILE_VEC = 2'h3;
  // status bit positions
  localparam int ST_READY_BIT = 0;
  localparam int ST_BUILTIN_SELF_TEST_BIT = 1;
  localparam int ST_FAIL_BIT = 2;
  localparam int ST_CAUSE_LSB = 4;
  localparam logic [1:0] CAUSE_HW   = 2'h1;
  localparam logic [1:0] CAUSE_INIT = 2'h2;

  typedef struct packed {
    logic [15:0] sel;
    logic [31:0] base;
    logic [31:0] limit;
    logic [7:0]  ar;
  } seg_t;

  typedef struct packed {
    logic [15:0] cw;
    logic [15:0] sw;
    logic [15:0] tag;
    logic [15:0] dataSel;
    logic [15:0] codeSel;
    logic [31:0] dataPtr;
    logic [31:0] instPtr;
  } fpu_env_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

  typedef enum logic [1:0] {ST_HWRESET, ST_BUILTIN_SELF_TEST, ST_INIT, ST_READY} seq_state_t;
endpackage
`default_nettype wire

// *** hw/cpu_arch_state_reset_init.sv ***
// architectural state reset and init sequencer with register port
//
// Our own choices: the register addresses and the strobed register port.
`default_nettype none
// How it works
// - code segment F000H, base FFFF0000H, present
// - data segments, ldt, task: zero selector, FFFFH
// - gdt and idt base zero, limit FFFFH
// - control word 0040H on reset, 037FH on initialise
// - status word and selectors cleared both ways
// - tag word 5555H on reset, FFFFH initialise
// - stack regs +0.0 on reset, initialise keeps
// - operand and instruction pointers cleared both ways
// - packed regs zeroed on reset, kept otherwise
// - vector regs zeroed on reset, init keeps
// - vector csr 1F80H on reset, init keeps
// - time stamp and perf state reset, init keeps
// - other msrs undefined at reset, init keeps
// - memory type ranges disabled at reset only
// - interrupt controller enabled at reset, init keeps
// - upper ten flag bits left undefined
// - cr0 keeps cd nw, sets bit 4
// - accumulator zero unless self-test failed
// - self-test never started by init
// - init keeps floating point and packed state
// - power-up cr0 reads 60000010H, real mode
// - hardware reset invalidates caches, tlbs, btb
// - init invalidates only tlbs and btb
// - data register gets identification after reset
module cpu_arch_state_reset_init
  import arch_reset_pkg::*;
#(
  parameter logic [31:0] IDENT_VALUE = 32'h0000_0a5a  // arbitrary identification value
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              resetPin,
  input  wire logic              initPin,
  input  wire logic              bistReqPin,
  input  wire logic              bistDone,
  input  wire logic              bistFail,
  input  wire bus_req_t          bus,
  output var  logic [DATA_W-1:0] rdata,
  output var  logic              coreReady,
  output var  logic              bistStart,
  output var  logic              cacheInvalidate,
  output var  logic              tlbInvalidate,
  output var  logic              btbInvalidate,
  output var  logic              lapicEnable
);

  logic [SYNC_PINS-1:0] sync1, sync2, sync3, pinLvl;
  logic                 initLvlQ;
  seq_state_t           state, next_state;
  logic                 applyHw, applyInit, fpuInitCmd, initRise;
  logic [1:0]           lastCause;
  logic [31:0]          cr0, flags, accum, dataRegD, vecCsr, msrMisc, mchkStatus;
  logic [63:0]          tscCount;
  logic [31:0]          perfSel [NUM_PERF];
  logic [31:0]          perfCnt [NUM_PERF];
  logic [1:0]           mtrrEn;
  logic [9:0]           fileSel;
  fpu_env_t             fpuEnv;
  seg_t                 segs    [NUM_SEGS];
  logic [FPU_W-1:0]     fpuStack [NUM_ENTRIES];
  logic [MM_W-1:0]      mmRegs   [NUM_ENTRIES];
  logic [VEC_W-1:0]     vecRegs  [NUM_ENTRIES];
  logic [DATA_W-1:0]    next_rdata;
  logic [1:0]           selWord, selFile;
  logic [3:0]           selEntry;
  logic                 fileWr;

  function automatic seg_t segReset(input int idx);
    seg_t s;
    s.sel   = ZERO_SELECTOR;
    s.base  = ZERO_BASE;
    s.limit = SEG_LIMIT;
    s.ar    = (idx < SEG_LOCAL_DESCRIPTOR_TABLE_REG) ? AR_PRW_ACC : AR_PRW;
    if (idx == SEG_CS) begin
      s.sel  = CS_SELECTOR;
      s.base = CS_BASE;
    end
    return s;
  endfunction

  function automatic logic [VEC_W-1:0] setWord(input logic [VEC_W-1:0] v,
                                               input logic [1:0] w,
                                               input logic [31:0] d);
    logic [VEC_W-1:0] r;
    r = v;
    r[w*32 +: 32] = d;
    return r;
  endfunction

  // pin synchronisers: a change counts when stages two and three agree
  genvar p;
  generate
    for (p = 0; p < SYNC_PINS; p++) begin : g_sync
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          sync1[p]  <= 1'b0;
          sync2[p]  <= 1'b0;
          sync3[p]  <= 1'b0;
          pinLvl[p] <= 1'b0;
        end else begin
          sync1[p] <= p == 0 ? resetPin : (p == 1 ? initPin : bistReqPin);
          sync2[p] <= sync1[p];
          sync3[p] <= sync2[p];
          if (sync2[p] == sync3[p]) begin
            pinLvl[p] <= sync3[p];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      initLvlQ <= 1'b0;
    end else begin
      initLvlQ <= pinLvl[1];
    end
  end

  assign initRise   = pinLvl[1] && !initLvlQ;
  assign applyHw    = (state == ST_HWRESET);
  assign applyInit  = (state == ST_INIT);
  assign fpuInitCmd = bus.wr && (bus.addr == OFF_FPU_INIT);
  assign selWord    = fileSel[SEL_WORD_LSB +: 2];
  assign selEntry   = fileSel[SEL_ENTRY_LSB +: 4];
  assign selFile    = fileSel[SEL_FILE_LSB +: 2];
  assign fileWr     = bus.wr && (bus.addr == OFF_FILE_DATA);

  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_HWRESET: begin
        if (!pinLvl[0]) begin
          next_state = pinLvl[2] ? ST_BUILTIN_SELF_TEST : ST_READY;
        end
      end
      ST_BUILTIN_SELF_TEST: begin
        if (bistDone) begin
          next_state = ST_READY;
        end
      end
      ST_INIT: next_state = ST_READY;
      ST_READY: begin
        if (initRise) begin
          next_state = ST_INIT;
        end
      end
      default: next_state = ST_HWRESET;
    endcase
    if (pinLvl[0]) begin
      next_state = ST_HWRESET;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state           <= ST_HWRESET;
      lastCause       <= CAUSE_HW;
      coreReady       <= 1'b0;
      bistStart       <= 1'b0;
      cacheInvalidate <= 1'b1;
      tlbInvalidate   <= 1'b1;
      btbInvalidate   <= 1'b1;
    end else begin
      state           <= next_state;
      coreReady       <= (next_state == ST_READY);
      bistStart       <= applyHw && (next_state == ST_BUILTIN_SELF_TEST);
      cacheInvalidate <= (next_state == ST_HWRESET);
      tlbInvalidate   <= (next_state == ST_HWRESET) || (next_state == ST_INIT);
      btbInvalidate   <= (next_state == ST_HWRESET) || (next_state == ST_INIT);
      if (next_state == ST_HWRESET) begin
        lastCause <= CAUSE_HW;
      end else if (next_state == ST_INIT) begin
        lastCause <= CAUSE_INIT;
      end
    end
  end

  // segment and descriptor table registers
  genvar s;
  generate
    for (s = 0; s < NUM_SEGS; s++) begin : g_seg
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          segs[s] <= segReset(s);
        end else if (applyHw || applyInit) begin
          segs[s] <= segReset(s);
        end else if (fileWr && selFile == FILE_SEG && selEntry == 4'(s)) begin
          case (selWord)
            2'h0:    segs[s].sel   <= bus.wdata[15:0];
            2'h1:    segs[s].base  <= bus.wdata;
            2'h2:    segs[s].limit <= bus.wdata;
            default: segs[s].ar    <= bus.wdata[7:0];
          endcase
        end
      end
    end
  endgenerate

  // control register zero, flags, accumulator, data register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cr0      <= CR0_POWERUP;
      flags    <= FLAGS_RESET;
      accum    <= ZERO_BASE;
      dataRegD <= IDENT_VALUE;
    end else if (applyHw || applyInit) begin
      cr0      <= (cr0 & CR0_KEEP_MASK) | CR0_SET_BITS;
      flags    <= (flags & FLAGS_UNDEF) | FLAGS_RESET;
      accum    <= ZERO_BASE;
      dataRegD <= IDENT_VALUE;
    end else if (state == ST_BUILTIN_SELF_TEST && bistDone) begin
      accum <= bistFail ? BUILTIN_SELF_TEST_FAIL : ZERO_BASE;
    end else if (bus.wr) begin
      if (bus.addr == OFF_CR0) begin
        cr0 <= bus.wdata;
      end
      if (bus.addr == OFF_FLAGS) begin
        flags <= bus.wdata;
      end
      if (bus.addr == OFF_ACCUM) begin
        accum <= bus.wdata;
      end
    end
  end

  // floating-point environment
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fpuEnv <= '{FCW_RESET, FSW_CLEAR, FTW_RESET, FSW_CLEAR, FSW_CLEAR, ZERO_BASE, ZERO_BASE};
    end else if (applyHw) begin
      fpuEnv <= '{FCW_RESET, FSW_CLEAR, FTW_RESET, FSW_CLEAR, FSW_CLEAR,
                  ZERO_BASE, ZERO_BASE};
    end else if (applyInit) begin
      fpuEnv <= fpuEnv;
    end else if (fpuInitCmd) begin
      fpuEnv <= '{FCW_FINIT, FSW_CLEAR, FTW_FINIT, FSW_CLEAR, FSW_CLEAR,
                  ZERO_BASE, ZERO_BASE};
    end else if (bus.wr) begin
      case (bus.addr)
        OFF_FPU_CW:   fpuEnv.cw <= bus.wdata[15:0];
        OFF_FPU_SW:   fpuEnv.sw <= bus.wdata[15:0];
        OFF_FPU_TAG:  fpuEnv.tag <= bus.wdata[15:0];
        OFF_FPU_SELS: {fpuEnv.codeSel, fpuEnv.dataSel} <= bus.wdata;
        OFF_FPU_DPTR: fpuEnv.dataPtr <= bus.wdata;
        OFF_FPU_IPTR: fpuEnv.instPtr <= bus.wdata;
        default:      fpuEnv <= fpuEnv;
      endcase
    end
  end

  // stack, packed and vector register files
  genvar e;
  generate
    for (e = 0; e < NUM_ENTRIES; e++) begin : g_file
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          fpuStack[e] <= '0;
          mmRegs[e]   <= '0;
          vecRegs[e]  <= '0;
        end else if (applyHw) begin
          fpuStack[e] <= '0;
          mmRegs[e]   <= '0;
          vecRegs[e]  <= '0;
        end else if (fileWr && !applyInit && selEntry == 4'(e)) begin
          // init and the initialise command leave these untouched
          if (selFile == FILE_FPU) begin
            fpuStack[e] <= FPU_W'(setWord(VEC_W'(fpuStack[e]), selWord, bus.wdata));
          end
          if (selFile == FILE_MM) begin
            mmRegs[e] <= MM_W'(setWord(VEC_W'(mmRegs[e]), selWord, bus.wdata));
          end
          if (selFile == FILE_VEC) begin
            vecRegs[e] <= setWord(vecRegs[e], selWord, bus.wdata);
          end
        end
      end
    end
  endgenerate

  // vector csr, model-specific state, memory types, interrupt controller
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      vecCsr      <= VCSR_RESET;
      mtrrEn      <= 2'h0;
      lapicEnable <= 1'b1;
      msrMisc     <= ZERO_BASE;
      mchkStatus  <= ZERO_BASE;
      fileSel     <= 10'h000;
    end else if (applyHw) begin
      vecCsr      <= VCSR_RESET;
      mtrrEn      <= 2'h0;
      lapicEnable <= 1'b1;
      // other msrs and machine-check state keep whatever they held
    end else if (bus.wr && !applyInit) begin
      case (bus.addr)
        OFF_VEC_CSR:  vecCsr <= bus.wdata;
        OFF_MEMORY_TYPE_RANGES_EN:  mtrrEn <= bus.wdata[1:0];
        OFF_LAPIC:    lapicEnable <= bus.wdata[0];
        OFF_MSR_MISC: msrMisc <= bus.wdata;
        OFF_MCHK:     mchkStatus <= bus.wdata;
        OFF_FILE_SEL: fileSel <= bus.wdata[9:0];
        default:      fileSel <= fileSel;
      endcase
    end
  end

  // time-stamp counter runs every cycle outside hardware reset
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tscCount <= 64'h0;
    end else if (applyHw) begin
      tscCount <= 64'h0;
    end else begin
      tscCount <= tscCount + 64'h1;
    end
  end

  // performance counters count cycles while select bit 0 is set
  genvar c;
  generate
    for (c = 0; c < NUM_PERF; c++) begin : g_perf
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          perfSel[c] <= ZERO_BASE;
          perfCnt[c] <= ZERO_BASE;
        end else if (applyHw) begin
          perfSel[c] <= ZERO_BASE;
          perfCnt[c] <= ZERO_BASE;
        end else if (bus.wr && bus.addr == OFF_PERF_SEL + ADDR_W'(c) * PERF_STRIDE) begin
          perfSel[c] <= bus.wdata;
        end else if (bus.wr && bus.addr == OFF_PERF_CNT + ADDR_W'(c) * PERF_STRIDE) begin
          perfCnt[c] <= bus.wdata;
        end else if (perfSel[c][0]) begin
          perfCnt[c] <= perfCnt[c] + 32'h1;
        end
      end
    end
  endgenerate

  // read mux
  always_comb begin
    next_rdata = '0;
    case (bus.addr)
      OFF_STATUS: begin
        next_rdata[ST_READY_BIT] = coreReady;
        next_rdata[ST_BUILTIN_SELF_TEST_BIT]  = (state == ST_BUILTIN_SELF_TEST);
        next_rdata[ST_FAIL_BIT]  = (accum != ZERO_BASE);
        next_rdata[ST_CAUSE_LSB +: 2] = lastCause;
      end
      OFF_CR0:       next_rdata = cr0;
      OFF_FLAGS:     next_rdata = flags;
      OFF_ACCUM:     next_rdata = accum;
      OFF_DATA_D:    next_rdata = dataRegD;
      OFF_FPU_CW:    next_rdata[15:0] = fpuEnv.cw;
      OFF_FPU_SW:    next_rdata[15:0] = fpuEnv.sw;
      OFF_FPU_TAG:   next_rdata[15:0] = fpuEnv.tag;
      OFF_FPU_SELS:  next_rdata = {fpuEnv.codeSel, fpuEnv.dataSel};
      OFF_FPU_DPTR:  next_rdata = fpuEnv.dataPtr;
      OFF_FPU_IPTR:  next_rdata = fpuEnv.instPtr;
      OFF_VEC_CSR:   next_rdata = vecCsr;
      OFF_TSC_LO:    next_rdata = tscCount[31:0];
      OFF_TSC_HI:    next_rdata = tscCount[63:32];
      OFF_MEMORY_TYPE_RANGES_EN:   next_rdata[1:0] = mtrrEn;
      OFF_LAPIC:     next_rdata[0] = lapicEnable;
      OFF_MSR_MISC:  next_rdata = msrMisc;
      OFF_MCHK:      next_rdata = mchkStatus;
      OFF_FILE_SEL:  next_rdata[9:0] = fileSel;
      OFF_FILE_DATA: begin
        case (selFile)
          FILE_SEG: begin
            if (selEntry < 4'(NUM_SEGS)) begin
              case (selWord)
                2'h0:    next_rdata[15:0] = segs[selEntry].sel;
                2'h1:    next_rdata = segs[selEntry].base;
                2'h2:    next_rdata = segs[selEntry].limit;
                default: next_rdata[7:0] = segs[selEntry].ar;
              endcase
            end
          end
          FILE_FPU: next_rdata = 32'(VEC_W'(fpuStack[selEntry[2:0]]) >> (selWord * 32));
          FILE_MM:  next_rdata = 32'(VEC_W'(mmRegs[selEntry[2:0]]) >> (selWord * 32));
          default:  next_rdata = 32'(vecRegs[selEntry[2:0]] >> (selWord * 32));
        endcase
      end
      default: begin
        if (bus.addr == OFF_PERF_SEL || bus.addr == OFF_PERF_SEL + PERF_STRIDE) begin
          next_rdata = perfSel[bus.addr[2]];
        end else if (bus.addr == OFF_PERF_CNT || bus.addr == OFF_PERF_CNT + PERF_STRIDE) begin
          next_rdata = perfCnt[bus.addr[2]];
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= '0;
    end else begin
      rdata <= bus.rd ? next_rdata : '0;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  cs_reload_a: assert property (applyHw |=> segs[SEG_CS].sel == CS_SELECTOR
      && segs[SEG_CS].base == CS_BASE && segs[SEG_CS].limit == SEG_LIMIT)
    else $error("code segment not reloaded");
  gdt_reload_a: assert property (applyInit |=> segs[SEG_GLOBAL_DESCRIPTOR_TABLE_REG].base == ZERO_BASE
      && segs[SEG_GLOBAL_DESCRIPTOR_TABLE_REG].limit == SEG_LIMIT && segs[SEG_GLOBAL_DESCRIPTOR_TABLE_REG].ar == AR_PRW)
    else $error("descriptor table not reloaded");
  fpu_words_a: assert property (fpuInitCmd && state == ST_READY |=> fpuEnv.cw == FCW_FINIT
      && fpuEnv.tag == FTW_FINIT && fpuEnv.sw == FSW_CLEAR)
    else $error("initialise command values wrong");
  fpu_hw_a: assert property (applyHw |=> fpuEnv.cw == FCW_RESET && fpuEnv.tag == FTW_RESET)
    else $error("fpu reset values wrong");
  init_keeps_a: assert property (applyInit |=> $stable(fpuEnv) && $stable(mmRegs[0])
      && $stable(vecCsr) && $stable(fpuStack[7]))
    else $error("init disturbed kept state");
  tsc_runs_a: assert property (applyInit |=> tscCount == $past(tscCount) + 64'h1)
    else $error("time stamp counter lost on init");
  no_builtin_self_test_a: assert property (applyInit |-> ##1 !bistStart [*2])
    else $error("self-test started by init");
  cr0_keep_a: assert property (applyHw |=> cr0 == (($past(cr0) & CR0_KEEP_MASK)
      | CR0_SET_BITS))
    else $error("cr0 reset value wrong");
  inval_a: assert property (applyInit |-> tlbInvalidate && btbInvalidate && !cacheInvalidate)
    else $error("init invalidation wrong");
  builtin_self_test_res_a: assert property (state == ST_BUILTIN_SELF_TEST && bistDone && !pinLvl[0]
      |=> (accum == ZERO_BASE) == !$past(bistFail) && coreReady)
    else $error("self-test result wrong");

  hw_seq_c: cover property (applyHw ##1 state == ST_BUILTIN_SELF_TEST ##[1:20] coreReady);
  init_seq_c: cover property (coreReady ##1 applyInit ##1 coreReady);
  finit_c: cover property (coreReady && fpuInitCmd);
  builtin_self_test_fail_c: cover property (state == ST_BUILTIN_SELF_TEST && bistDone && bistFail);

endmodule
`default_nettype wire

// *** bench/platform_model.sv ***
// platform model: reset and init pins plus a self-test engine
`default_nettype none
module platform_model (
  input  wire logic mclk,
  input  wire logic bistStart,
  input  wire logic coreReady,
  input  wire logic tlbInvalidate,
  output var  logic resetPin = 1'b0,
  output var  logic initPin = 1'b0,
  output var  logic bistReqPin = 1'b0,
  output var  logic bistDone = 1'b0,
  output var  logic bistFail = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt = 4'h0;
  logic       failNext = 1'b0;
  // self-test engine answers five cycles after launch
  always @(posedge mclk) begin
    bistDone <= (cnt == 4'h1);
    bistFail <= failNext & (cnt == 4'h1);
    cnt <= bistStart ? 4'h5 : cnt - {3'h0, cnt != 4'h0};
  end
  task automatic hold_reset(input logic b, input logic f);
    @(posedge mclk);
    bistReqPin <= b;
    failNext <= f;
    resetPin <= 1'b1;
    for (int i = 0; i < 40 && coreReady !== 1'b0; i++) @(negedge mclk);
  endtask
  task automatic drop_reset();
    @(posedge mclk);
    resetPin <= 1'b0;
    for (int i = 0; i < 80 && coreReady !== 1'b1; i++) @(negedge mclk);
    bistReqPin <= 1'b0;
  endtask
  task automatic raise_init();
    @(posedge mclk);
    initPin <= 1'b1;
    for (int i = 0; i < 40 && tlbInvalidate !== 1'b1; i++) @(negedge mclk);
  endtask
  task automatic drop_init();
    @(posedge mclk);
    initPin <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// *** bench/cpu_arch_state_reset_init_tb.sv ***
// self-checking bench for the reset and init sequencer
`default_nettype none
module cpu_arch_state_reset_init_tb import arch_reset_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] IDENT = 32'h0000_0c3c;  // arbitrary identification value
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  bus_req_t bus = '0;
  logic [DATA_W-1:0] rdata;
  logic coreReady, bistStart, cacheInvalidate, tlbInvalidate, btbInvalidate, lapicEnable;
  logic resetPin, initPin, bistReqPin, bistDone, bistFail;
  int mismatches = 0;
  int comparisons = 0;
  int starts = 0;
  int n;
  cpu_arch_state_reset_init #(.IDENT_VALUE(IDENT)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
    .resetPin(resetPin), .initPin(initPin), .bistReqPin(bistReqPin), .bistDone(bistDone),
    .bistFail(bistFail), .bus(bus), .rdata(rdata), .coreReady(coreReady),
    .bistStart(bistStart), .cacheInvalidate(cacheInvalidate), .tlbInvalidate(tlbInvalidate),
    .btbInvalidate(btbInvalidate), .lapicEnable(lapicEnable));
  platform_model plat_u (.mclk(mclk), .bistStart(bistStart), .coreReady(coreReady),
    .tlbInvalidate(tlbInvalidate), .resetPin(resetPin), .initPin(initPin),
    .bistReqPin(bistReqPin), .bistDone(bistDone), .bistFail(bistFail));
  initial begin
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) if (bistStart === 1'b1) starts <= starts + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    @(negedge mclk);
    chk(rdata & m, e);
  endtask
  task automatic rf(input logic [31:0] s, input logic [31:0] e);
    wr(OFF_FILE_SEL, s);
    rd(OFF_FILE_DATA, '1, e);
  endtask
  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #40000;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(OFF_CR0, '1, CR0_POWERUP);
    rd(OFF_FPU_CW, '1, {16'h0, FCW_RESET});
    rd(OFF_FPU_TAG, '1, {16'h0, FTW_RESET});
    rd(OFF_VEC_CSR, '1, VCSR_RESET);
    rd(OFF_DATA_D, '1, IDENT);
    rd(OFF_FLAGS, ~FLAGS_UNDEF, FLAGS_RESET);
    rf(32'h000, {16'h0, CS_SELECTOR});
    rf(32'h001, CS_BASE);
    rf(32'h003, {24'h0, AR_PRW_ACC});
    rf(32'h006, SEG_LIMIT);
    rf(32'h01b, {24'h0, AR_PRW});
    rf(32'h021, ZERO_BASE);
    $display("test power_up done");
    wr(OFF_FPU_CW, 32'h0abc);
    wr(OFF_FPU_DPTR, 32'h0123);
    wr(OFF_FILE_SEL, 32'h100);
    wr(OFF_FILE_DATA, 32'h55);
    wr(OFF_FILE_SEL, 32'h200);
    wr(OFF_FILE_DATA, 32'h66);
    wr(OFF_FPU_INIT, 32'h0);
    rd(OFF_FPU_CW, '1, {16'h0, FCW_FINIT});
    rd(OFF_FPU_TAG, '1, {16'h0, FTW_FINIT});
    rd(OFF_FPU_SW, '1, 32'h0);
    rd(OFF_FPU_DPTR, '1, 32'h0);
    rf(32'h100, 32'h55);
    rf(32'h200, 32'h66);
    $display("test fpu_init done");
    wr(OFF_FPU_CW, 32'h0abc);
    wr(OFF_VEC_CSR, 32'h1f00);
    wr(OFF_PERF_SEL, 32'h2);
    wr(OFF_MEMORY_TYPE_RANGES_EN, 32'h3);
    wr(OFF_MSR_MISC, 32'h5a);
    wr(OFF_LAPIC, 32'h0);
    wr(OFF_CR0, 32'h1);
    wr(OFF_FILE_SEL, 32'h300);
    wr(OFF_FILE_DATA, 32'h77);
    n = starts;
    plat_u.raise_init();
    chk({28'h0, coreReady, tlbInvalidate, btbInvalidate, cacheInvalidate}, 32'h6);
    plat_u.drop_init();
    rd(OFF_FPU_CW, '1, 32'h0abc);
    rd(OFF_VEC_CSR, '1, 32'h1f00);
    rd(OFF_PERF_SEL, '1, 32'h2);
    rd(OFF_MEMORY_TYPE_RANGES_EN, '1, 32'h3);
    rd(OFF_MSR_MISC, '1, 32'h5a);
    chk({30'h0, coreReady, lapicEnable}, 32'h2);
    rd(OFF_CR0, '1, CR0_SET_BITS);
    rd(OFF_STATUS, 32'h37, 32'h21);
    rf(32'h300, 32'h77);
    rf(32'h200, 32'h66);
    chk(32'(starts), 32'(n));
    $display("test init done");
    wr(OFF_CR0, 32'h4000_0000);
    plat_u.hold_reset(1'b1, 1'b1);
    chk({28'h0, coreReady, tlbInvalidate, btbInvalidate, cacheInvalidate}, 32'h7);
    plat_u.drop_reset();
    rd(OFF_ACCUM, '1, BUILTIN_SELF_TEST_FAIL);
    rd(OFF_CR0, '1, 32'h4000_0010);
    rd(OFF_FPU_CW, '1, {16'h0, FCW_RESET});
    rd(OFF_VEC_CSR, '1, VCSR_RESET);
    rd(OFF_PERF_SEL, '1, 32'h0);
    rd(OFF_MEMORY_TYPE_RANGES_EN, '1, 32'h0);
    chk({30'h0, coreReady, lapicEnable}, 32'h3);
    rd(OFF_STATUS, 32'h37, 32'h15);
    rf(32'h200, 32'h0);
    rf(32'h300, 32'h0);
    rf(32'h100, 32'h0);
    chk(32'(starts), 32'(n + 1));
    plat_u.hold_reset(1'b1, 1'b0);
    plat_u.drop_reset();
    rd(OFF_ACCUM, '1, 32'h0);
    $display("test hw_reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
